// file: inc/rtcal_consts.svh
`ifndef RTCAL_CONSTS_SVH
`define RTCAL_CONSTS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define RTCAL_ADDR_TRIM 4'h7
`define RTCAL_ADDR_WK_MIN 4'h8
`define RTCAL_ADDR_WK_HOUR 4'h9
`define RTCAL_ADDR_WK_DAYS 4'hA
`define RTCAL_ADDR_DY_MIN 4'hB
`define RTCAL_ADDR_DY_HOUR 4'hC

// ****************************************************************
// field layout
// ****************************************************************
`define RTCAL_TRIM_SIGN_BIT 6
`define RTCAL_MIN_W 7
`define RTCAL_HOUR_W 6
`define RTCAL_DAYS_W 7
`define RTCAL_WDAY_W 3
`define RTCAL_TRIM_W 7
`define RTCAL_DAY_LAST 3'h6

// ****************************************************************
// reset values
// ****************************************************************
`define RTCAL_RST_TRIM 7'h00
`define RTCAL_RST_MIN 7'h00
`define RTCAL_RST_HOUR 6'h00
`define RTCAL_RST_DAYS 7'h00
`define RTCAL_RST_BYTE 8'h00

// ****************************************************************
// timing counts
// ****************************************************************
`define RTCAL_CNT_W 16
`define RTCAL_BASE_PERIOD 16'h8000
`define RTCAL_SEC_00 7'h00
`define RTCAL_SEC_20 7'h20
`define RTCAL_SEC_40 7'h40

`endif

// file: inc/rtcal_pkg.sv
`include "rtcal_consts.svh"

package rtcal_pkg;

	typedef logic [3:0] rtcal_addr_t;
	typedef logic [7:0] rtcal_byte_t;
	typedef logic [`RTCAL_MIN_W-1:0] rtcal_min_t;
	typedef logic [`RTCAL_HOUR_W-1:0] rtcal_hour_t;
	typedef logic [`RTCAL_DAYS_W-1:0] rtcal_days_t;
	typedef logic [`RTCAL_WDAY_W-1:0] rtcal_wday_t;
	typedef logic [`RTCAL_TRIM_W-1:0] rtcal_trim_t;
	typedef logic [`RTCAL_CNT_W-1:0] rtcal_cnt_t;

	typedef enum logic [1:0] {
		RTCAL_TRIM_NONE = 2'b00,
		RTCAL_TRIM_LONG = 2'b01,
		RTCAL_TRIM_SHORT = 2'b10
	} rtcal_trim_mode_t;

endpackage : rtcal_pkg

// file: src/rtcal_trim_dec.sv
`timescale 1ns/100ps

module rtcal_trim_dec (
	// trim code
	input wire rtcal_pkg::rtcal_trim_t trim_code,
	// adjusted second length
	output rtcal_pkg::rtcal_cnt_t adj_period
);
	import rtcal_pkg::*;

	logic trim_sign;
	logic [5:0] trim_magnitude;
	logic [7:0] long_step;
	logic [7:0] short_step;
	rtcal_trim_mode_t mode;
	rtcal_cnt_t base;

	assign trim_sign = trim_code[`RTCAL_TRIM_SIGN_BIT];
	assign trim_magnitude = trim_code[5:0];
	assign base = `RTCAL_BASE_PERIOD;

	// magnitudes 0 and 1 leave the second untouched for either sign
	assign mode = (trim_magnitude[5:1] == 5'h00) ? RTCAL_TRIM_NONE :
		(trim_sign ? RTCAL_TRIM_SHORT : RTCAL_TRIM_LONG);

	assign long_step = {1'b0, trim_magnitude - 6'h01, 1'b0};
	assign short_step = {1'b0, (~trim_magnitude) + 6'h01, 1'b0};

	always_comb begin
		case (mode)
			RTCAL_TRIM_LONG: adj_period = base + {8'h00, long_step};
			RTCAL_TRIM_SHORT: adj_period = base - {8'h00, short_step};
			RTCAL_TRIM_NONE: adj_period = base;
			default: adj_period = base;
		endcase
	end

endmodule : rtcal_trim_dec

// file: src/rtcal_alarm_cmp.sv
`timescale 1ns/100ps

module rtcal_alarm_cmp #(
	parameter bit USE_DAYS = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// current time
	input wire rtcal_pkg::rtcal_min_t cur_min,
	input wire rtcal_pkg::rtcal_hour_t cur_hour,
	input wire rtcal_pkg::rtcal_wday_t weekday_code,
	// alarm setting
	input wire rtcal_pkg::rtcal_min_t alarm_min,
	input wire rtcal_pkg::rtcal_hour_t alarm_hour,
	input wire rtcal_pkg::rtcal_days_t day_enables,
	// one-cycle match pulse
	output logic match_ff
);
	import rtcal_pkg::*;

	rtcal_min_t prev_min_ff;
	logic primed_ff;
	logic [`RTCAL_DAYS_W-1:0] day_sel;
	logic day_hit;
	logic time_hit;
	logic min_changed;
	logic nxt_match;

	// one compare per day code; code 7 selects nothing
	genvar gi;
	generate
		for (gi = 0; gi < `RTCAL_DAYS_W; gi = gi + 1) begin : g_day
			assign day_sel[gi] = day_enables[gi] && (weekday_code == rtcal_wday_t'(gi));
		end
	endgenerate

	// an all-zero mask can never hit, which silences the weekly alarm
	assign day_hit = USE_DAYS ? (|day_sel) : 1'b1;
	// hour compared as raw code, so 12/32 midnight/noon needs no translation
	assign time_hit = (cur_min == alarm_min) && (cur_hour == alarm_hour);
	assign min_changed = primed_ff && (cur_min != prev_min_ff);
	assign nxt_match = min_changed && time_hit && day_hit;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prev_min_ff <= `RTCAL_RST_MIN;
			primed_ff <= 1'b0;
			match_ff <= 1'b0;
		end else begin
			prev_min_ff <= cur_min;
			primed_ff <= 1'b1;
			match_ff <= nxt_match;
		end
	end

endmodule : rtcal_alarm_cmp

// file: src/rtcal_top.sv
// Summary of operation
// - code 0000111 stretches an adjusted second to 32780 crystal clocks.
// - code 1111110 shortens an adjusted second to 32764 crystal clocks.
// - code 0000001 keeps the adjusted second at 32768 clocks.
// - adjustment happens every 20 seconds in two-clock steps, about 3ppm each.
// - trim changes only clocks per second, never the 32 kHz output.
// - weekly minute at 8h holds seven BCD bits; bit 7 reads zero.
// - weekly hour holds six bits; bit 5 is pm or tens; 7:6 read zero.
// - weekly day mask at Ah enables days 000 to 110; bit 7 zero.
// - an all-zero day mask silences the weekly alarm.
// - twelve-hour alarm hours use 12 for midnight, 32 for noon.
// - daily minute at Bh holds seven BCD bits; bit 7 reads zero.
// - daily hour at Ch holds six bits; bits 7:6 read zero.
// - after oscillator halt alarm fields are undefined; upper bits read zero.
// - sign 0 adds (mag-1)*2; sign 1 subtracts (~mag+1)*2.
// - a trim write skips adjustment in that same 00/20/40 second.
// - weekday code counts 000 to 110 then wraps.
`timescale 1ns/100ps

module rtcal_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// internal register port
	input wire rtcal_pkg::rtcal_addr_t reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire rtcal_pkg::rtcal_byte_t reg_wdata,
	output rtcal_pkg::rtcal_byte_t reg_rdata_ff,
	// crystal clock level, sampled
	input wire logic xtal_in,
	output logic clk32_out_ff,
	// current time from the counters
	input wire rtcal_pkg::rtcal_min_t cur_sec,
	input wire rtcal_pkg::rtcal_min_t cur_min,
	input wire rtcal_pkg::rtcal_hour_t cur_hour,
	input wire rtcal_pkg::rtcal_wday_t weekday_code,
	input wire logic osc_halt_flag,
	// events
	output logic sec_tick_ff,
	output logic wk_alarm_match_ff,
	output logic dy_alarm_match_ff
);
	import rtcal_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic is_adj_point(input rtcal_min_t sec);
		is_adj_point = (sec == `RTCAL_SEC_00) || (sec == `RTCAL_SEC_20) ||
			(sec == `RTCAL_SEC_40);
	endfunction : is_adj_point

	function automatic logic addr_hit(input rtcal_addr_t a, input rtcal_addr_t target);
		addr_hit = (a == target);
	endfunction : addr_hit

	// stored fields are narrower than a byte; the rest is tied low on the way out
	function automatic rtcal_byte_t pad7(input logic [6:0] field);
		pad7 = {1'b0, field};
	endfunction : pad7

	function automatic rtcal_byte_t pad6(input logic [5:0] field);
		pad6 = {2'b00, field};
	endfunction : pad6

	// ****************************************************************
	// register storage
	// ****************************************************************
	rtcal_trim_t trim_ff;
	rtcal_min_t wk_alarm_min_digits_ff;
	rtcal_hour_t wk_alarm_hour_ff;
	rtcal_days_t wk_alarm_day_enables_ff;
	rtcal_min_t dy_alarm_min_digits_ff;
	rtcal_hour_t dy_alarm_hour_ff;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// decoded once, shared by the write strobes and the read select
	logic sel_trim;
	logic sel_wk_min;
	logic sel_wk_hour;
	logic sel_wk_days;
	logic sel_dy_min;
	logic sel_dy_hour;

	assign sel_trim = addr_hit(reg_addr, `RTCAL_ADDR_TRIM);
	assign sel_wk_min = addr_hit(reg_addr, `RTCAL_ADDR_WK_MIN);
	assign sel_wk_hour = addr_hit(reg_addr, `RTCAL_ADDR_WK_HOUR);
	assign sel_wk_days = addr_hit(reg_addr, `RTCAL_ADDR_WK_DAYS);
	assign sel_dy_min = addr_hit(reg_addr, `RTCAL_ADDR_DY_MIN);
	assign sel_dy_hour = addr_hit(reg_addr, `RTCAL_ADDR_DY_HOUR);

	// ****************************************************************
	// write data fields
	// ****************************************************************
	rtcal_trim_t wdata_trim;
	rtcal_min_t wdata_min;
	rtcal_hour_t wdata_hour;
	rtcal_days_t wdata_days;

	// each field is cut to its stored width here
	assign wdata_trim = reg_wdata[6:0];
	assign wdata_min = reg_wdata[6:0];
	assign wdata_hour = reg_wdata[5:0];
	assign wdata_days = reg_wdata[6:0];

	logic halt_clear;
	logic wr_trim;
	logic wr_wk_min;
	logic wr_wk_hour;
	logic wr_wk_days;
	logic wr_dy_min;
	logic wr_dy_hour;

	// strobes are single cycles; back-to-back writes need no spacing
	assign wr_trim = reg_wr_en && sel_trim;
	assign wr_wk_min = reg_wr_en && sel_wk_min;
	assign wr_wk_hour = reg_wr_en && sel_wk_hour;
	assign wr_wk_days = reg_wr_en && sel_wk_days;
	assign wr_dy_min = reg_wr_en && sel_dy_min;
	assign wr_dy_hour = reg_wr_en && sel_dy_hour;
	// a trim write in the same cycle beats the halt clear
	assign halt_clear = osc_halt_flag && !wr_trim;

	// upper bits are simply not stored, so writes to them vanish
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wk_alarm_min_digits_ff <= `RTCAL_RST_MIN;
			wk_alarm_hour_ff <= `RTCAL_RST_HOUR;
			wk_alarm_day_enables_ff <= `RTCAL_RST_DAYS;
			dy_alarm_min_digits_ff <= `RTCAL_RST_MIN;
			dy_alarm_hour_ff <= `RTCAL_RST_HOUR;
		end else begin
			if (wr_wk_min) begin
				wk_alarm_min_digits_ff <= wdata_min;
			end
			if (wr_wk_hour) begin
				wk_alarm_hour_ff <= wdata_hour;
			end
			if (wr_wk_days) begin
				wk_alarm_day_enables_ff <= wdata_days;
			end
			if (wr_dy_min) begin
				dy_alarm_min_digits_ff <= wdata_min;
			end
			if (wr_dy_hour) begin
				dy_alarm_hour_ff <= wdata_hour;
			end
		end
	end

	// oscillator halt returns trim to its default; alarm fields are kept as is
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trim_ff <= `RTCAL_RST_TRIM;
		end else if (wr_trim) begin
			trim_ff <= wdata_trim;
		end else if (halt_clear) begin
			// halt is a level, so the clear repeats until it drops
			trim_ff <= `RTCAL_RST_TRIM;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	rtcal_byte_t img_trim;
	rtcal_byte_t img_wk_min;
	rtcal_byte_t img_wk_hour;
	rtcal_byte_t img_wk_days;
	rtcal_byte_t img_dy_min;
	rtcal_byte_t img_dy_hour;
	rtcal_byte_t rd_mux;

	// bits above each field read as zero, whatever was written there
	assign img_trim = pad7(trim_ff);
	assign img_wk_min = pad7(wk_alarm_min_digits_ff);
	assign img_wk_hour = pad6(wk_alarm_hour_ff);
	assign img_wk_days = pad7(wk_alarm_day_enables_ff);
	assign img_dy_min = pad7(dy_alarm_min_digits_ff);
	assign img_dy_hour = pad6(dy_alarm_hour_ff);

	// unmapped addresses fall through to zero
	assign rd_mux =
		sel_trim ? img_trim :
		sel_wk_min ? img_wk_min :
		sel_wk_hour ? img_wk_hour :
		sel_wk_days ? img_wk_days :
		sel_dy_min ? img_dy_min :
		sel_dy_hour ? img_dy_hour :
		`RTCAL_RST_BYTE;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata_ff <= `RTCAL_RST_BYTE;
		end else if (reg_rd_en) begin
			reg_rdata_ff <= rd_mux;
		end
	end

	// ****************************************************************
	// crystal edge and clock output
	// ****************************************************************
	logic xtal_prev_ff;
	logic xtal_tick;

	assign xtal_tick = xtal_in && !xtal_prev_ff;

	// output follows the crystal alone; trim never reaches it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			xtal_prev_ff <= 1'b0;
			clk32_out_ff <= 1'b0;
		end else begin
			xtal_prev_ff <= xtal_in;
			clk32_out_ff <= xtal_in;
		end
	end

	// ****************************************************************
	// trimmed second counter
	// ****************************************************************
	rtcal_cnt_t adj_period;
	rtcal_cnt_t sel_period;
	rtcal_cnt_t sec_cnt_ff;
	rtcal_cnt_t nxt_sec_cnt;
	logic trim_wr_sec_ff;
	logic nxt_trim_wr_sec;
	logic adj_now;
	logic sec_end;
	rtcal_cnt_t sec_last;
	rtcal_cnt_t cnt_inc;

	rtcal_trim_dec u_trim_dec (
		.trim_code(trim_ff),
		.adj_period(adj_period)
	);

	// a write inside the current second blocks its adjustment; set wins
	assign nxt_trim_wr_sec = wr_trim || (trim_wr_sec_ff && !sec_end);
	assign adj_now = is_adj_point(cur_sec) && !trim_wr_sec_ff && !wr_trim;
	assign sel_period = adj_now ? adj_period : `RTCAL_BASE_PERIOD;
	// cur_sec is read live; it must hold still until the second ends
	assign sec_last = sel_period - 16'h0001;
	assign cnt_inc = sec_cnt_ff + 16'h0001;
	// compare with >= so a shorter period never lets the count run past
	assign sec_end = xtal_tick && (sec_cnt_ff >= sec_last);
	assign nxt_sec_cnt = sec_end ? 16'h0000 :
		(xtal_tick ? cnt_inc : sec_cnt_ff);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sec_cnt_ff <= 16'h0000;
			trim_wr_sec_ff <= 1'b0;
			sec_tick_ff <= 1'b0;
		end else begin
			sec_cnt_ff <= nxt_sec_cnt;
			trim_wr_sec_ff <= nxt_trim_wr_sec;
			sec_tick_ff <= sec_end;
		end
	end

	// ****************************************************************
	// alarm comparators
	// ****************************************************************
	rtcal_days_t every_day;

	// the daily alarm ignores the weekday, so its mask is held full
	assign every_day = 7'h7F;

	// host owns valid BCD values and the weekday mapping of each enable
	rtcal_alarm_cmp #(
		.USE_DAYS(1'b1)
	) u_wk_alarm (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.cur_min(cur_min),
		.cur_hour(cur_hour),
		.weekday_code(weekday_code),
		.alarm_min(wk_alarm_min_digits_ff),
		.alarm_hour(wk_alarm_hour_ff),
		.day_enables(wk_alarm_day_enables_ff),
		.match_ff(wk_alarm_match_ff)
	);

	rtcal_alarm_cmp #(
		.USE_DAYS(1'b0)
	) u_dy_alarm (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.cur_min(cur_min),
		.cur_hour(cur_hour),
		.weekday_code(weekday_code),
		.alarm_min(dy_alarm_min_digits_ff),
		.alarm_hour(dy_alarm_hour_ff),
		.day_enables(every_day),
		.match_ff(dy_alarm_match_ff)
	);

endmodule : rtcal_top

// file: test/rtcal_top_assertions.sv
`timescale 1ns/100ps

module rtcal_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register port
	input wire rtcal_pkg::rtcal_addr_t reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire rtcal_pkg::rtcal_byte_t reg_wdata,
	input wire rtcal_pkg::rtcal_byte_t reg_rdata_ff,
	// crystal and time
	input wire logic xtal_in,
	input wire logic clk32_out_ff,
	input wire rtcal_pkg::rtcal_min_t cur_min,
	input wire rtcal_pkg::rtcal_hour_t cur_hour,
	input wire rtcal_pkg::rtcal_wday_t weekday_code,
	// events
	input wire logic wk_alarm_match_ff,
	input wire logic dy_alarm_match_ff
);
	import rtcal_pkg::*;
	// shadow of the weekly day mask and the daily alarm time, written the same edge as the block's copy
	rtcal_days_t wmask_ff;
	rtcal_min_t dmin_ff;
	rtcal_hour_t dhour_ff;
	wire logic mapped = reg_addr >= `RTCAL_ADDR_TRIM && reg_addr <= `RTCAL_ADDR_DY_HOUR;
	wire logic hour_reg = reg_addr == `RTCAL_ADDR_WK_HOUR || reg_addr == `RTCAL_ADDR_DY_HOUR;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wmask_ff <= 7'h00;
			dmin_ff <= 7'h00;
			dhour_ff <= 6'h00;
		end else if (reg_wr_en) begin
			if (reg_addr == `RTCAL_ADDR_WK_DAYS) wmask_ff <= reg_wdata[6:0];
			if (reg_addr == `RTCAL_ADDR_DY_MIN) dmin_ff <= reg_wdata[6:0];
			if (reg_addr == `RTCAL_ADDR_DY_HOUR) dhour_ff <= reg_wdata[5:0];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_rd_unmapped: assert property (reg_rd_en && !mapped |=> reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	a_rd_bit7_zero: assert property (reg_rdata_ff[7] == 1'b0)
		else $error("read bit 7 set");
	a_hour_upper_zero: assert property (reg_rd_en && hour_reg |=> reg_rdata_ff[7:6] == 2'h0)
		else $error("hour upper bits set");
	a_clk32_follow: assert property (!sys_rst |=> clk32_out_ff == $past(xtal_in))
		else $error("clock output off crystal");
	a_wk_zero_mask: assert property (wk_alarm_match_ff |-> wmask_ff != 7'h00)
		else $error("weekly alarm with empty mask");
	a_wk_day_enable: assert property (wk_alarm_match_ff |->
		$past(weekday_code) < 3'h7 && wmask_ff[$past(weekday_code)])
		else $error("weekly alarm on disabled day");
	a_dy_time_match: assert property (dy_alarm_match_ff |->
		$past(cur_min) == dmin_ff && $past(cur_hour) == dhour_ff)
		else $error("daily alarm on wrong time");
	a_dy_fires_once: assert property (dy_alarm_match_ff |=> !dy_alarm_match_ff)
		else $error("daily alarm longer than a cycle");
endmodule : rtcal_chk

// file: test/rtcal_xtal_model.sv
`timescale 1ns/100ps

module rtcal_xtal_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// second pulse
	input wire logic sec_tick_ff,
	// crystal and seconds counter
	output logic xtal_in,
	output rtcal_pkg::rtcal_min_t cur_sec,
	// crystal clocks in the last second
	output int last_cnt
);
	import rtcal_pkg::*;
	int cnt;
	initial begin
		xtal_in = 1'b0;
		cur_sec = 7'h00;
		cnt = 0;
		last_cnt = 0;
	end
	// crystal runs free at the fastest rate the sampler can see
	always @(negedge core_clk) begin
		if (sys_rst) begin
			xtal_in = 1'b0;
			cnt = 0;
		end else begin
			if (sec_tick_ff) begin
				last_cnt = cnt;
				cnt = 0;
				// plain increment: only the first few seconds are ever run
				cur_sec = cur_sec + 7'h01;
			end
			if (!xtal_in) cnt = cnt + 1;
			xtal_in = !xtal_in;
		end
	end
endmodule : rtcal_xtal_model

// file: test/rtcal_top_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

module rtcal_top_tb_top;
	import rtcal_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	rtcal_addr_t reg_addr = 4'h0;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	rtcal_byte_t reg_wdata = 8'h00;
	rtcal_byte_t reg_rdata_ff;
	logic xtal_in, clk32_out_ff, sec_tick_ff, wk, dy;
	rtcal_min_t cur_sec;
	rtcal_min_t cur_min = 7'h00;
	rtcal_hour_t cur_hour = 6'h32;
	rtcal_wday_t weekday_code = 3'h0;
	logic osc_halt_flag = 1'b0;
	int last_cnt, err_count = 0, n_tests = 0;
	rtcal_byte_t masks [6] = '{8'h7F, 8'h7F, 8'h3F, 8'h7F, 8'h7F, 8'h3F};
	always #2.5 core_clk = ~core_clk;
	rtcal_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff), .xtal_in(xtal_in), .clk32_out_ff(clk32_out_ff),
		.cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour),
		.weekday_code(weekday_code), .osc_halt_flag(osc_halt_flag),
		.sec_tick_ff(sec_tick_ff), .wk_alarm_match_ff(wk), .dy_alarm_match_ff(dy));
	rtcal_xtal_model xm (.core_clk(core_clk), .sys_rst(sys_rst), .sec_tick_ff(sec_tick_ff),
		.xtal_in(xtal_in), .cur_sec(cur_sec), .last_cnt(last_cnt));
	task automatic wr(input rtcal_addr_t a, input rtcal_byte_t d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask : wr
	task automatic rd(input rtcal_addr_t a, input rtcal_byte_t ex);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		`CHK("reg_rdata_ff", ex, reg_rdata_ff)
	endtask : rd
	// window of four cycles covers either answer latency
	task automatic step_min(input rtcal_min_t m, input logic ew, input logic ed);
		logic sw, sd;
		sw = 1'b0;
		sd = 1'b0;
		@(negedge core_clk);
		cur_min = m;
		repeat (4) begin
			@(negedge core_clk);
			sw = sw | wk;
			sd = sd | dy;
		end
		`CHK("wk_alarm_match_ff", ew, sw)
		`CHK("dy_alarm_match_ff", ed, sd)
	endtask : step_min
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (90000) @(posedge core_clk);
		err_count++;
		test_done();
	end
	initial begin
		int k;
		k = 0;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(rtcal_addr_t'(7 + i), 8'h00);
			wr(rtcal_addr_t'(7 + i), 8'hFF);
			rd(rtcal_addr_t'(7 + i), masks[i]);
		end
		wr(4'hD, 8'h5A);
		rd(4'hD, 8'h00);
		$display("test registers done");
		wr(`RTCAL_ADDR_WK_MIN, 8'h30);
		wr(`RTCAL_ADDR_WK_HOUR, 8'h32);
		wr(`RTCAL_ADDR_DY_MIN, 8'h30);
		wr(`RTCAL_ADDR_DY_HOUR, 8'h32);
		for (int d = 0; d < 7; d++) begin
			wr(`RTCAL_ADDR_WK_DAYS, 8'(1 << d));
			weekday_code = 3'(d);
			step_min(7'h29, 1'b0, 1'b0);
			step_min(7'h30, 1'b1, 1'b1);
			weekday_code = 3'((d + 1) % 7);
			step_min(7'h29, 1'b0, 1'b0);
			step_min(7'h30, 1'b0, 1'b1);
		end
		step_min(7'h30, 1'b0, 1'b0);
		wr(`RTCAL_ADDR_WK_DAYS, 8'h00);
		step_min(7'h29, 1'b0, 1'b0);
		step_min(7'h30, 1'b0, 1'b1);
		cur_hour = 6'h12;
		step_min(7'h29, 1'b0, 1'b0);
		step_min(7'h30, 1'b0, 1'b0);
		$display("test alarms done");
		// every write lands inside the first second, so none may stretch it
		wr(`RTCAL_ADDR_TRIM, 8'h7E);
		`CHK("adj_period", 16'h7FFC, uut.adj_period)
		wr(`RTCAL_ADDR_TRIM, 8'h01);
		`CHK("adj_period", 16'h8000, uut.adj_period)
		wr(`RTCAL_ADDR_TRIM, 8'h07);
		`CHK("adj_period", 16'h800C, uut.adj_period)
		while (sec_tick_ff !== 1'b1 && k < 70000) begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 70000) err_count++;
		@(negedge core_clk);
		`CHK("second length", 32'h00008000, last_cnt)
		rd(`RTCAL_ADDR_TRIM, 8'h07);
		@(negedge core_clk);
		osc_halt_flag = 1'b1;
		@(negedge core_clk);
		osc_halt_flag = 1'b0;
		rd(`RTCAL_ADDR_TRIM, 8'h00);
		$display("test trim done");
		test_done();
	end
endmodule : rtcal_top_tb_top

bind rtcal_top rtcal_chk chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
	.reg_rdata_ff(reg_rdata_ff), .xtal_in(xtal_in), .clk32_out_ff(clk32_out_ff),
	.cur_min(cur_min), .cur_hour(cur_hour), .weekday_code(weekday_code),
	.wk_alarm_match_ff(wk_alarm_match_ff), .dy_alarm_match_ff(dy_alarm_match_ff));
